// [bench/start_ctrl_model.sv]
// External machine controller model: start lines and error reset.
// Assumes the bench calls its tasks; released lines read off (0).
`timescale 1ns/1ps
module start_ctrl_model (
  input  logic       pclk,
  output logic [4:0] start_in,
  output logic       error_reset_in
);
  initial begin
    start_in = 5'h00;
    error_reset_in = 1'b0;
  end
  task automatic lines(input logic [4:0] v);
    @(posedge pclk);
    start_in <= v;
  endtask
  // Weighted lines, odd parity only when par is set; bad breaks the parity on purpose
  task automatic send(input logic [3:0] s, input bit par, input bit bad);
    lines({par & (~^s ^ bad), s});
  endtask
  task automatic clr();
    @(posedge pclk);
    error_reset_in <= 1'b1;
    repeat (4) @(posedge pclk);
    error_reset_in <= 1'b0;
  endtask
endmodule // start_ctrl_model

// [bench/weld_option_decode_sva.sv]
// Checker for the weld option decode block, bound to its ports.
// Assumes pins reach outputs through a three-edge synchroniser path.
`timescale 1ns/1ps
module weld_option_decode_sva #(
  parameter [24:0] HOLD_CYCLES = 25'd30
) (
  input logic       pclk,
  input logic       presetn,
  input logic [7:0] option_bank_a,
  input logic [7:0] option_bank_b,
  input logic       shared_in,
  input logic       seq_data_valid,
  input logic       seq_low_current,
  input logic       supply_comp_mode,
  input logic       primary_feedback,
  input logic       pulsation_mode,
  input logic       gain_modes_enabled,
  input logic [7:0] rise_correction_gain,
  input logic       data_out_valid,
  input logic       interlock_active,
  input logic       retry_req,
  input logic [7:0] retry_pct,
  input logic       hold_finish_out,
  input logic       start_req
);
  logic [2:0]  up;
  logic [24:0] hcnt;
  // Cycles since reset and length of the current hold-finish level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up   <= 3'h0;
      hcnt <= 25'h0;
    end else begin
      up   <= (up == 3'h7) ? up : up + 3'h1;
      hcnt <= hold_finish_out ? hcnt + 25'h1 : 25'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_supply_mode: assert property (
    up == 3'h7 |-> supply_comp_mode == $past(option_bank_a[0], 3)) else $error("supply mode");
  a_primary_fb: assert property (
    up == 3'h7 |-> primary_feedback == $past(option_bank_a[1], 3)) else $error("feedback");
  a_pulse_select: assert property (
    up == 3'h7 |-> pulsation_mode == $past(option_bank_b[0], 3)) else $error("pulsation");
  a_gain_modes: assert property (
    up == 3'h7 |-> gain_modes_enabled == $past(option_bank_b[6], 3)) else $error("gain modes");
  a_fixed_gain: assert property (
    !gain_modes_enabled |-> rise_correction_gain == 8'h32) else $error("fixed gain");
  a_data_gate: assert property (
    data_out_valid |-> $past(seq_data_valid) && $past(option_bank_b[4], 3)) else $error("data out");
  a_interlock_in: assert property (
    up == 3'h7 |-> interlock_active == ($past(option_bank_b[1], 3) && $past(shared_in, 3)))
    else $error("interlock");
  a_retry_boost: assert property (
    retry_req |-> $past(seq_low_current) && $past(option_bank_a[5], 3) ##1 retry_pct == 8'h69)
    else $error("retry");
  a_hold_length: assert property (
    $fell(hold_finish_out) |-> hcnt == HOLD_CYCLES
    || (!$past(option_bank_a[6], 3) && hcnt > HOLD_CYCLES)) else $error("hold length");
  cover property (start_req);
  cover property ($fell(hold_finish_out));
  cover property (retry_req);
endmodule // weld_option_decode_sva

bind weld_option_decode weld_option_decode_sva #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
  .pclk, .presetn, .option_bank_a, .option_bank_b, .shared_in, .seq_data_valid,
  .seq_low_current, .supply_comp_mode, .primary_feedback, .pulsation_mode,
  .gain_modes_enabled, .rise_correction_gain, .data_out_valid, .interlock_active,
  .retry_req, .retry_pct, .hold_finish_out, .start_req);

// [bench/weld_option_decode_tb_top.sv]
// Self-checking bench for the weld option decode block.
// Assumes short settle and hold counts; sequencer events come from here.
`timescale 1ns/1ps
`include "weld_opt_map.vh"
module weld_option_decode_tb_top;
  localparam int HC = 30;
  localparam int SC = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, shared_in = 0;
  logic cur_on = 0, cnt_hit = 0, ilk_out = 0, er, got;
  logic [7:0]  paddr = 0, option_bank_a = 0, option_bank_b = 0, pul = 0, sdata = 0, a, b;
  logic [31:0] pwdata = 0, rd, v;
  logic [3:0]  sch;
  wire [4:0] start_in;
  wire [31:0] prdata;
  wire [3:0] start_schedule;
  wire [7:0] error_code, retry_pct, off_time, pulse_count, data_out, rise_correction_gain;
  wire [7:0] interval_correction_gain;
  wire pready, pslverr, supply_comp_mode, primary_feedback, timing_out, start_req, start_held;
  wire retry_req, hold_finish_out, pulsation_mode, shared_out, data_out_valid, error_reset_in;
  wire regulation_update, gain_modes_enabled, monitor_error, count_clear, interlock_active;
  int miscompares = 0, total_checks = 0, cyc = 0, ru = 0, cc = 0, n, q[$];

  weld_option_decode #(.SETTLE_CYCLES(SC), .HOLD_CYCLES(HC)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .option_bank_a, .option_bank_b, .start_in, .error_reset_in, .shared_in,
    .seq_squeeze_start(pul[0]), .seq_weld_start(pul[1]), .seq_weld_end(pul[2]),
    .seq_current_on(cur_on), .seq_low_current(pul[3]), .seq_monitor_error(pul[4]),
    .seq_hold_done(pul[5]), .seq_count_reached(cnt_hit), .seq_interlock_out(ilk_out),
    .seq_half_cycle(pul[6]), .seq_data(sdata), .seq_data_valid(pul[7]),
    .supply_comp_mode, .primary_feedback, .timing_out, .start_req, .start_schedule,
    .start_held, .error_code, .monitor_error, .retry_req, .retry_pct, .hold_finish_out,
    .pulsation_mode, .off_time, .pulse_count, .count_clear, .interlock_active,
    .shared_out, .data_out, .data_out_valid, .regulation_update, .gain_modes_enabled,
    .rise_correction_gain, .interval_correction_gain);
  start_ctrl_model m (.pclk(pclk), .start_in(start_in), .error_reset_in(error_reset_in));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (regulation_update === 1'b1) ru <= ru + 1;
    if (count_clear === 1'b1) cc <= cc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cy(int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pz(int i);
    @(posedge pclk);
    pul[i] <= 1'b1;
    @(posedge pclk);
    pul[i] <= 1'b0;
  endtask
  task automatic sw(logic [7:0] sa, logic [7:0] sb);
    @(posedge pclk);
    option_bank_a <= sa;
    option_bank_b <= sb;
    cy(4);
  endtask
  task automatic apb(bit w, logic [7:0] ad, logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic run_start(output logic g, output logic [3:0] s);
    g = 0;
    s = 0;
    repeat (SC + 30) begin
      @(posedge pclk);
      if (start_req === 1'b1) {g, s} = {1'b1, start_schedule};
    end
    m.lines(5'h00);
    cy(4);
  endtask
  task automatic hold_len(output int k);
    k = 0;
    repeat (HC + 30) begin
      @(posedge pclk);
      if (hold_finish_out === 1'b1) k++;
    end
  endtask

  initial begin
    void'($urandom(32'h073d));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cy(2);
    ck("retry_pct", 8'd100, retry_pct);
    apb(0, `OFS_GAIN, 0, rd, er);
    ck("gain_reg", 32'h3232, rd);
    apb(0, `OFS_OPTIONS, 0, rd, er);
    ck("options", 0, rd);
    apb(0, 8'h14, 0, rd, er);
    ck("unmapped", 1, er);
    for (int i = 0; i < 4; i++) begin
      {a, b, v} = {$urandom, $urandom};
      b[7] = 1'b0;
      {cnt_hit, ilk_out, shared_in, sdata} <= {v[2:0], v[15:8]};
      sw(a & 8'h7f, b);
      apb(1, `OFS_OFF_PHASE, v, rd, er);
      apb(1, `OFS_GAIN, v, rd, er);
      ru = 0;
      repeat (4) pz(6);
      pz(7);
      cy(0);
      ck("data_out", b[4] ? v[15:8] : 8'h0, data_out);
      ck("data_valid", b[4], data_out_valid);
      cy(4);
      ck("supply", a[0], supply_comp_mode);
      ck("feedback", a[1], primary_feedback);
      ck("off_time", b[0] ? 8'h0 : v[7:0], off_time);
      ck("pulse_count", b[0] ? v[7:0] : 8'h0, pulse_count);
      ck("shared_out", b[1] ? v[1] : v[2], shared_out);
      ck("interlock", b[1] & v[0], interlock_active);
      ck("reg_update", b[5] ? 2 : 4, ru);
      ck("rise_gain", b[6] ? v[7:0] : `GAIN_DEFAULT, rise_correction_gain);
      ck("int_gain", b[6] ? v[15:8] : `GAIN_DEFAULT, interval_correction_gain);
      apb(0, `OFS_OPTIONS, 0, rd, er);
      ck("options", {b, a & 8'h7f}, rd);
    end
    for (int j = 0; j < 2; j++) begin
      shared_in <= 1'b0;
      sw(0, j ? 8'h02 : 8'h00);
      cc = 0;
      shared_in <= 1'b1;
      cy(6);
      ck("count_clear", !j, cc);
      ck("interlock_on", j, interlock_active);
    end
    sw(8'h20, 0);
    pz(3);
    cy(2);
    ck("retry_pct", 8'd105, retry_pct);
    sw(0, 0);
    for (int s = 1; s < 16; s++) begin
      q.push_back(s);
      m.send(s, 0, 0);
      run_start(got, sch);
      ck("sched", {1'b1, 4'(q.pop_front())}, {got, sch});
    end
    ck("retry_pct", 8'd100, retry_pct);
    sw(8'h08, 0);
    m.send(5, 1, 0);
    run_start(got, sch);
    ck("par_ok", 5'h15, {got, sch});
    m.send(6, 1, 1);
    run_start(got, sch);
    ck("par_bad", 9'h002, {got, error_code});
    m.clr();
    sw(8'h08, 8'h08);
    m.send(6, 1, 1);
    run_start(got, sch);
    ck("four_mode", 13'h1200, {got, sch, error_code});
    m.lines(5'h04);
    cy(5);
    m.lines(5'h0d);
    run_start(got, sch);
    ck("four_low", 5'h11, {got, sch});
    sw(0, 8'h04);
    apb(1, `OFS_CONTROL, 9, rd, er);
    m.lines(5'h08);
    run_start(got, sch);
    ck("panel", 5'h19, {got, sch});
    sw(8'h40, 0);
    pz(5);
    hold_len(n);
    ck("hold_pulse", HC, n);
    sw(0, 0);
    m.lines(5'h01);
    pz(5);
    hold_len(n);
    m.lines(5'h00);
    ck("hold_level", 1, n > HC);
    cy(10);
    pz(4);
    pz(5);
    hold_len(n);
    ck("mon_err_off", HC, n);
    ck("mon_err", 1, monitor_error);
    m.clr();
    cy(0);
    ck("mon_clr", 0, monitor_error);
    sw(8'h80, 0);
    pz(4);
    pz(5);
    hold_len(n);
    m.send(3, 0, 0);
    run_start(got, sch);
    ck("mon_err_on", 0, {n, got});
    m.clr();
    pz(1);
    cy(1);
    ck("timing", 1, timing_out);
    sw(8'h04, 0);
    ck("flicker_off", 0, timing_out);
    cur_on <= 1'b1;
    cy(2);
    ck("flicker_on", 1, timing_out);
    pz(2);
    cy(2);
    ck("timing_end", 0, timing_out);
    sw(8'h10, 0);
    pz(5);
    pz(0);
    cy(1);
    ck("held_sqz", 1, start_held);
    pz(5);
    sw(0, 0);
    pz(0);
    cy(1);
    ck("held_none", 0, start_held);
    pz(1);
    cy(1);
    ck("held_weld", 1, start_held);
    report_and_stop();
  end
endmodule // weld_option_decode_tb_top

// [verilog/sched_decode.v]
// Start-line decoder: 15-schedule binary, 4-schedule lowest line,
// or panel schedule with the lines as trigger only.
// Assumes start lines are already synchronised to pclk.
`timescale 1ns/1ps
`include "weld_opt_map.vh"
module sched_decode #(
  parameter [24:0] SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [4:0] start_lines,
  input  wire       four_mode,
  input  wire       parity_en,
  input  wire       panel_mode,
  input  wire [3:0] panel_sched,
  output reg        sched_valid,
  output reg  [3:0] sched,
  output reg        parity_err
);
  localparam ST_IDLE    = 2'd0;
  localparam ST_SETTLE  = 2'd1;
  localparam ST_RELEASE = 2'd2;

  reg  [1:0]  state;
  reg  [24:0] cnt;
  wire        any_on = |start_lines[3:0];
  wire        odd    = ^start_lines;

  // Lowest-weighted line still on, as schedule 1..4
  function [3:0] lowest;
    input [3:0] l;
    begin
      if (l[0])      lowest = 4'h1;
      else if (l[1]) lowest = 4'h2;
      else if (l[2]) lowest = 4'h3;
      else if (l[3]) lowest = 4'h4;
      else           lowest = 4'h0;
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      cnt         <= 25'h0;
      sched_valid <= 1'b0;
      sched       <= 4'h0;
      parity_err  <= 1'b0;
    end else begin
      sched_valid <= 1'b0;
      parity_err  <= 1'b0;
      case (state)
        ST_IDLE: if (any_on) begin
          if (panel_mode) begin
            sched       <= panel_sched;
            sched_valid <= 1'b1;
            state       <= ST_RELEASE;
          end else if (four_mode) begin
            cnt   <= SETTLE_CYCLES - 25'd1;
            state <= ST_SETTLE;
          end else if (parity_en && !odd) begin
            parity_err <= 1'b1;
            state      <= ST_RELEASE;
          end else begin
            sched       <= start_lines[3:0];
            sched_valid <= 1'b1;
            state       <= ST_RELEASE;
          end
        end
        ST_SETTLE: begin
          if (cnt == 25'h0) begin
            sched       <= lowest(start_lines[3:0]);
            sched_valid <= |start_lines[3:0];
            state       <= ST_RELEASE;
          end else begin
            cnt <= cnt - 25'd1;
          end
        end
        ST_RELEASE: if (!any_on) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // sched_decode

// [verilog/sync2.v]
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherency is kept.
`timescale 1ns/1ps
module sync2 #(
  parameter W = 23
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync2

// [verilog/weld_opt_map.vh]
// Constants for the weld option decode block: register map, fields,
// reset values and timing counts. Definitions only.
`ifndef WELD_OPT_MAP_VH
`define WELD_OPT_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_OPTIONS      8'h00
`define OFS_CONTROL      8'h04
`define OFS_STATUS       8'h08
`define OFS_GAIN         8'h0c
`define OFS_OFF_PHASE    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL_ERR_CLR_BIT  8
`define GAIN_INT_LSB     8
`define ST_SCHED_LSB     8
`define ST_MON_ERR_BIT   12
`define ST_HELD_BIT      13
`define ST_WELD_BIT      14
`define ST_REFUSE_BIT    15

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define GAIN_DEFAULT     8'h32
`define PANEL_SCHED_RST  4'h1
`define ERR_CODE_PARITY  8'h02
`define RETRY_BASE_PCT   8'h64
`define RETRY_BOOST_PCT  8'h05

// ----------------------------------------------------------------
// Timing: times in ms, clock in kHz, counts derived
// ----------------------------------------------------------------
`define CLK_KHZ          25'd100000
`define START_SETTLE_MS  25'd20
`define HOLD_FINISH_MS   25'd200
`define SETTLE_CYCLES    (`START_SETTLE_MS * `CLK_KHZ)
`define HOLD_CYCLES      (`HOLD_FINISH_MS * `CLK_KHZ)

`endif

// [verilog/weld_option_decode.v]
// Option-switch decoder for a resistance-weld sequencer, with an APB
// register slave. Assumes the sequencer core on pclk supplies the
// interval events; switches and start pins are asynchronous.
//
// How it works
// - Bank A bit 1 picks supply compensation
// - Bank A bit 2 picks primary feedback
// - Bank A bit 3 picks flicker over timing
// - Parity checked only in 15-schedule, A4 on
// - Even start-line count flags error 02
// - Bank A bit 5 latches start at squeeze
// - Bank A bit 6 retries with 5 percent
// - Bank A bit 7 makes hold-finish a pulse
// - Bank A bit 8 blocks on monitor error
// - Bank B bit 1 pulsation, else repeat
// - Bank B bit 2 shared pins as interlock
// - Bank B bit 3 uses panel schedule
// - 15-schedule mode decodes binary start lines
// - 4-schedule waits 20 ms, lowest line
// - Bank B bit 5 enables data output
// - Bank B bit 6 regulates per full cycle
// - Bank B bit 7 makes gains writable
// - Both gains reset to 50
// - All switches read off after reset
`timescale 1ns/1ps
`include "weld_opt_map.vh"
module weld_option_decode #(
  parameter [24:0] SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter [24:0] HOLD_CYCLES   = `HOLD_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  option_bank_a,
  input  wire [7:0]  option_bank_b,
  input  wire [4:0]  start_in,
  input  wire        error_reset_in,
  input  wire        shared_in,
  input  wire        seq_squeeze_start,
  input  wire        seq_weld_start,
  input  wire        seq_weld_end,
  input  wire        seq_current_on,
  input  wire        seq_low_current,
  input  wire        seq_monitor_error,
  input  wire        seq_hold_done,
  input  wire        seq_count_reached,
  input  wire        seq_interlock_out,
  input  wire        seq_half_cycle,
  input  wire [7:0]  seq_data,
  input  wire        seq_data_valid,
  output reg         supply_comp_mode,
  output reg         primary_feedback,
  output reg         timing_out,
  output reg         start_req,
  output reg  [3:0]  start_schedule,
  output reg         start_held,
  output reg  [7:0]  error_code,
  output reg         monitor_error,
  output reg         retry_req,
  output reg  [7:0]  retry_pct,
  output reg         hold_finish_out,
  output reg         pulsation_mode,
  output reg  [7:0]  off_time,
  output reg  [7:0]  pulse_count,
  output reg         count_clear,
  output reg         interlock_active,
  output reg         shared_out,
  output reg  [7:0]  data_out,
  output reg         data_out_valid,
  output reg         regulation_update,
  output reg         gain_modes_enabled,
  output reg  [7:0]  rise_correction_gain,
  output reg  [7:0]  interval_correction_gain
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [22:0] pins_s;
  wire [7:0]  bank_a;
  wire [7:0]  bank_b;
  wire [4:0]  start_s;
  wire        err_rst_s;
  wire        shared_s;

  sync2 #(
    .W (23)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({shared_in, error_reset_in, start_in,
                option_bank_b, option_bank_a}),
    .q       (pins_s)
  );

  assign bank_a    = pins_s[7:0];
  assign bank_b    = pins_s[15:8];
  assign start_s   = pins_s[20:16];
  assign err_rst_s = pins_s[21];
  assign shared_s  = pins_s[22];

  wire start_any = |start_s[3:0];

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg  [3:0] panel_sched;
  reg  [7:0] rise_gain;
  reg  [7:0] int_gain;
  reg  [7:0] off_phase_select;
  reg        weld_active;
  reg        shared_d;
  reg        half_phase;
  reg  [24:0] hold_cnt;

  wire setup  = psel & ~penable;
  wire wr_go  = psel & penable & pready & pwrite;
  wire is_opt = (paddr == `OFS_OPTIONS);
  wire is_ctl = (paddr == `OFS_CONTROL);
  wire is_st  = (paddr == `OFS_STATUS);
  wire is_gn  = (paddr == `OFS_GAIN);
  wire is_off = (paddr == `OFS_OFF_PHASE);
  wire hit    = is_opt | is_ctl | is_st | is_gn | is_off;
  wire sw_clr = wr_go & is_ctl & pwdata[`CTL_ERR_CLR_BIT];
  wire err_clr = sw_clr | err_rst_s;
  wire refuse = bank_a[7] & monitor_error;

  reg  [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    if (is_opt) begin
      rd_mux[15:0] = {bank_b, bank_a};
    end
    if (is_ctl) begin
      rd_mux[3:0] = panel_sched;
    end
    if (is_st) begin
      rd_mux[7:0]                          = error_code;
      rd_mux[`ST_SCHED_LSB+3:`ST_SCHED_LSB] = start_schedule;
      rd_mux[`ST_MON_ERR_BIT]              = monitor_error;
      rd_mux[`ST_HELD_BIT]                 = start_held;
      rd_mux[`ST_WELD_BIT]                 = weld_active;
      rd_mux[`ST_REFUSE_BIT]               = refuse;
    end
    if (is_gn) begin
      rd_mux[15:0] = {interval_correction_gain, rise_correction_gain};
    end
    if (is_off) begin
      rd_mux[7:0] = off_phase_select;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one access cycle, answered from the setup edge
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_sched      <= `PANEL_SCHED_RST;
      rise_gain        <= `GAIN_DEFAULT;
      int_gain         <= `GAIN_DEFAULT;
      off_phase_select <= 8'h0;
    end else if (wr_go) begin
      if (is_ctl) begin
        panel_sched <= pwdata[3:0];
      end
      if (is_gn && bank_b[6]) begin
        rise_gain <= pwdata[7:0];
        int_gain  <= pwdata[`GAIN_INT_LSB+7:`GAIN_INT_LSB];
      end
      if (is_off) begin
        off_phase_select <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Schedule selection
  // ----------------------------------------------------------------
  wire       sched_valid;
  wire [3:0] sched;
  wire       parity_err;

  sched_decode #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_sched (
    .pclk        (pclk),
    .presetn     (presetn),
    .start_lines (start_s),
    .four_mode   (bank_b[3]),
    .parity_en   (bank_a[3] & ~bank_b[3]),
    .panel_mode  (bank_b[2]),
    .panel_sched (panel_sched),
    .sched_valid (sched_valid),
    .sched       (sched),
    .parity_err  (parity_err)
  );

  // ----------------------------------------------------------------
  // Start request, self-hold, errors
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_req      <= 1'b0;
      start_schedule <= 4'h0;
      start_held     <= 1'b0;
      error_code     <= 8'h0;
      monitor_error  <= 1'b0;
      weld_active    <= 1'b0;
    end else begin
      start_req <= sched_valid & ~refuse;
      if (sched_valid && !refuse) begin
        start_schedule <= sched;
      end
      // Self-hold point chosen by switch
      if (bank_a[4] ? seq_squeeze_start : seq_weld_start) begin
        start_held <= 1'b1;
      end else if (seq_hold_done) begin
        start_held <= 1'b0;
      end
      if (parity_err) begin
        error_code <= `ERR_CODE_PARITY;
      end else if (err_clr) begin
        error_code <= 8'h0;
      end
      if (seq_monitor_error) begin
        monitor_error <= 1'b1;
      end else if (err_clr) begin
        monitor_error <= 1'b0;
      end
      if (seq_weld_start) begin
        weld_active <= 1'b1;
      end else if (seq_weld_end) begin
        weld_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hold-finish output
  // ----------------------------------------------------------------
  wire hold_go = seq_hold_done & ~refuse;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt        <= 25'h0;
      hold_finish_out <= 1'b0;
    end else if (hold_go) begin
      hold_cnt        <= HOLD_CYCLES - 25'd1;
      hold_finish_out <= 1'b1;
    end else if (hold_cnt != 25'h0) begin
      hold_cnt <= hold_cnt - 25'd1;
    end else if (hold_finish_out && (bank_a[6] || !start_any)) begin
      hold_finish_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode, retry, shared pins, data out, regulation pace
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_comp_mode         <= 1'b0;
      primary_feedback         <= 1'b0;
      timing_out               <= 1'b0;
      retry_req                <= 1'b0;
      retry_pct                <= `RETRY_BASE_PCT;
      pulsation_mode           <= 1'b0;
      off_time                 <= 8'h0;
      pulse_count              <= 8'h0;
      count_clear              <= 1'b0;
      interlock_active         <= 1'b0;
      shared_out               <= 1'b0;
      shared_d                 <= 1'b0;
      data_out                 <= 8'h0;
      data_out_valid           <= 1'b0;
      half_phase               <= 1'b0;
      regulation_update        <= 1'b0;
      gain_modes_enabled       <= 1'b0;
      rise_correction_gain     <= `GAIN_DEFAULT;
      interval_correction_gain <= `GAIN_DEFAULT;
    end else begin
      supply_comp_mode <= bank_a[0];
      primary_feedback <= bank_a[1];
      timing_out <= weld_active & (~bank_a[2] | seq_current_on);
      retry_req <= seq_low_current & bank_a[5];
      if (seq_low_current && bank_a[5]) begin
        retry_pct <= `RETRY_BASE_PCT + `RETRY_BOOST_PCT;
      end else if (start_req) begin
        retry_pct <= `RETRY_BASE_PCT;
      end
      pulsation_mode <= bank_b[0];
      off_time       <= bank_b[0] ? 8'h0 : off_phase_select;
      pulse_count    <= bank_b[0] ? off_phase_select : 8'h0;
      shared_d         <= shared_s;
      count_clear      <= ~bank_b[1] & shared_s & ~shared_d;
      interlock_active <= bank_b[1] & shared_s;
      shared_out <= bank_b[1] ? seq_interlock_out : seq_count_reached;
      data_out_valid <= bank_b[4] & seq_data_valid;
      data_out       <= (bank_b[4] & seq_data_valid) ? seq_data : 8'h0;
      if (seq_half_cycle) begin
        half_phase <= ~half_phase;
      end
      regulation_update <= seq_half_cycle & (~bank_b[5] | half_phase);
      gain_modes_enabled       <= bank_b[6];
      rise_correction_gain     <= bank_b[6] ? rise_gain : `GAIN_DEFAULT;
      interval_correction_gain <= bank_b[6] ? int_gain : `GAIN_DEFAULT;
    end
  end

endmodule // weld_option_decode
